// *** include/fan_cfg_regs.vh ***
`ifndef FAN_CFG_REGS_VH
`define FAN_CFG_REGS_VH

// Register map
`define CFG1_ADDR          8'h00
`define CFG2_ADDR          8'h01

// Power-on values
`define CFG1_RESET         8'hD4
`define CFG2_RESET         8'h3D

// First configuration register fields
`define CFG1_ALERT_EN_BIT  1

// Second configuration register fields
`define CFG2_SOFT_RST_BIT  7
`define CFG2_LOW_SUP_BIT   6
`define CFG2_REM_OT_BIT    5
`define CFG2_LOC_OT_BIT    4

// Serial address of this device; value is arbitrary
`define DEV_SER_ADDR       7'h2C

// Serial engine timing: bits in a byte
`define BITS_PER_BYTE      4'h8

`endif

// *** rtl/pin_sync.v ***
module pin_sync #(
   parameter WIDTH = 2
) (
   // Clock and reset
   input  wire             i_sys_clk,
   input  wire             i_rst_n,
   // Pins
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);

   reg [WIDTH-1:0] meta;
   reg [WIDTH-1:0] stable;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         // Idle-high reset matches released bus lines
         always @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               meta[g]   <= 1'b1;
               stable[g] <= 1'b1;
            end else begin
               meta[g]   <= i_async[g];
               stable[g] <= meta[g];
            end
         end
      end
   endgenerate

   assign o_sync = stable;

endmodule

// *** rtl/soft_reset_irq_cfg.v ***
// Summary of operation
// - Writing one to bit 7 of the second register resets the device.
// - The soft reset bit clears itself and always reads back as zero.
// - Reset fires on the clock rise of the data LSB and is not acked.
// - Bit 6 lets a set low-supply flag raise an interrupt, or not.
// - Bit 5 lets a set remote over-temp flag raise an interrupt, or not.
// - Bit 5 powers up set unless the remote sensor has failed at reset.
// - Bit 4 gates the local over-temp flag and powers up set.
// - The second register sits at address 0x01 and resets to 0x3D.
// - Bit 6 powers up cleared, keeping low-supply events silent.
// - Enabled interrupts are shown by pulling the alert line low.
// - Alert asserts only while bit 1 of the first register is set.
`include "fan_cfg_regs.vh"

module soft_reset_irq_cfg (
   // Clock and reset
   input  wire       i_sys_clk,
   input  wire       i_nrst,
   // Serial bus pins
   input  wire       i_scl,
   input  wire       i_sda,
   output reg        o_sda_out,
   output reg        o_sda_oe,
   // Alert pin, open drain
   output reg        o_alert_out,
   output reg        o_alert_oe,
   // Status flags from the monitor
   input  wire       i_low_supply_flag,
   input  wire       i_remote_overtemp_flag,
   input  wire       i_local_overtemp_flag,
   input  wire       i_remote_sensor_fail,
   // Register contents and reset to the rest of the device
   output reg  [7:0] o_cfg1,
   output reg  [7:0] o_cfg2,
   output reg        o_soft_reset
);

   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_PTR  = 3'h2;
   localparam [2:0] S_WDAT = 3'h3;
   localparam [2:0] S_RDAT = 3'h4;
   localparam [2:0] S_ACK  = 3'h5;
   localparam [2:0] S_MACK = 3'h6;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and pin sampling

   reg        rst_meta;
   reg        rst_n;
   wire [1:0] pins_s;
   wire       scl_s;
   wire       sda_s;
   reg        scl_d;
   reg        sda_d;

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   pin_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (rst_n),
      .i_async   ({i_scl, i_sda}),
      .o_sync    (pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // Register read decode

   function [7:0] reg_read;
      input [7:0] ptr;
      input [7:0] cfg1;
      input [7:0] cfg2;
      begin
         case (ptr)
            `CFG1_ADDR: reg_read = cfg1;
            `CFG2_ADDR: reg_read = cfg2;
            default:    reg_read = 8'h00;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Serial engine and registers

   reg  [2:0] state;
   reg  [2:0] after_ack;
   reg  [3:0] cnt;
   reg  [7:0] shift;
   reg  [7:0] ptr;
   reg        strap_pending;
   wire [7:0] next_byte = {shift[6:0], sda_s};
   wire [7:0] rd_byte   = reg_read(ptr, o_cfg1, o_cfg2);

   // Soft reset on bit 7 write
   // Caught at the LSB rising edge
   wire soft_hit = (state == S_WDAT) && scl_rise &&
                   (cnt == `BITS_PER_BYTE - 4'h1) &&
                   (ptr == `CFG2_ADDR) && shift[6];

   always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state         <= S_IDLE;
         after_ack     <= S_IDLE;
         cnt           <= 4'h0;
         shift         <= 8'h00;
         ptr           <= 8'h00;
         scl_d         <= 1'b1;
         sda_d         <= 1'b1;
         o_sda_out     <= 1'b0;
         o_sda_oe      <= 1'b0;
         o_cfg1        <= `CFG1_RESET;
         o_cfg2        <= `CFG2_RESET;
         o_soft_reset  <= 1'b0;
         strap_pending <= 1'b1;
      end else if (o_soft_reset) begin
         // Bit 7 never stored, reads zero
         state         <= S_IDLE;
         after_ack     <= S_IDLE;
         cnt           <= 4'h0;
         shift         <= 8'h00;
         ptr           <= 8'h00;
         scl_d         <= scl_s;
         sda_d         <= sda_s;
         o_sda_oe      <= 1'b0;
         o_cfg1        <= `CFG1_RESET;
         o_cfg2        <= `CFG2_RESET;
         o_soft_reset  <= 1'b0;
         strap_pending <= 1'b1;
      end else begin
         scl_d        <= scl_s;
         sda_d        <= sda_s;
         o_soft_reset <= soft_hit;
         // Failed sensor at reset drops enable
         if (strap_pending) begin
            strap_pending <= 1'b0;
            if (i_remote_sensor_fail)
               o_cfg2[`CFG2_REM_OT_BIT] <= 1'b0;
         end
         if (start_c) begin
            state    <= S_ADDR;
            cnt      <= 4'h0;
            o_sda_oe <= 1'b0;
         end else if (stop_c) begin
            state    <= S_IDLE;
            o_sda_oe <= 1'b0;
         end else if (!soft_hit) begin
            case (state)
               S_ADDR, S_PTR, S_WDAT: begin
                  if (scl_rise) begin
                     shift <= next_byte;
                     cnt   <= cnt + 4'h1;
                  end else if (scl_fall && cnt == `BITS_PER_BYTE) begin
                     cnt <= 4'h0;
                     if (state == S_ADDR) begin
                        if (shift[7:1] == `DEV_SER_ADDR) begin
                           o_sda_oe  <= 1'b1;
                           state     <= S_ACK;
                           after_ack <= shift[0] ? S_RDAT : S_PTR;
                        end else begin
                           state <= S_IDLE;
                        end
                     end else begin
                        if (state == S_PTR) begin
                           ptr <= shift;
                        end else if (ptr == `CFG1_ADDR) begin
                           o_cfg1 <= shift;
                        end else if (ptr == `CFG2_ADDR) begin
                           o_cfg2 <= {1'b0, shift[6:0]};
                        end
                        o_sda_oe  <= 1'b1;
                        state     <= S_ACK;
                        after_ack <= S_WDAT;
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     state <= after_ack;
                     cnt   <= 4'h0;
                     if (after_ack == S_RDAT) begin
                        shift    <= rd_byte;
                        o_sda_oe <= ~rd_byte[7];
                     end else begin
                        o_sda_oe <= 1'b0;
                     end
                  end
               end
               S_RDAT: begin
                  if (scl_fall) begin
                     if (cnt == `BITS_PER_BYTE - 4'h1) begin
                        o_sda_oe <= 1'b0;
                        state    <= S_MACK;
                     end else begin
                        shift    <= {shift[6:0], 1'b0};
                        o_sda_oe <= ~shift[6];
                        cnt      <= cnt + 4'h1;
                     end
                  end
               end
               S_MACK: begin
                  // Master NACK ends the read; ACK repeats the byte
                  if (scl_rise && sda_s) begin
                     state <= S_IDLE;
                  end else if (scl_fall) begin
                     state    <= S_RDAT;
                     cnt      <= 4'h0;
                     shift    <= rd_byte;
                     o_sda_oe <= ~rd_byte[7];
                  end
               end
               default: begin
                  state <= S_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alert generation

   wire alert_req =
      (i_low_supply_flag      & o_cfg2[`CFG2_LOW_SUP_BIT]) |
      (i_remote_overtemp_flag & o_cfg2[`CFG2_REM_OT_BIT])  |
      (i_local_overtemp_flag  & o_cfg2[`CFG2_LOC_OT_BIT]);

   always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_alert_out <= 1'b0;
         o_alert_oe  <= 1'b0;
      end else begin
         o_alert_out <= 1'b0;
         o_alert_oe  <= alert_req & o_cfg1[`CFG1_ALERT_EN_BIT] &
                        ~o_soft_reset;
      end
   end

endmodule

// *** tb/soft_reset_irq_cfg_chk.sv ***
module soft_reset_irq_cfg_chk (
   // Clock and reset
   input logic       i_sys_clk,
   input logic       i_nrst,
   // Status inputs
   input logic       i_low_supply_flag,
   input logic       i_remote_overtemp_flag,
   input logic       i_local_overtemp_flag,
   input logic       i_remote_sensor_fail,
   // Outputs watched
   input logic       o_sda_out,
   input logic       o_sda_oe,
   input logic       o_alert_out,
   input logic       o_alert_oe,
   input logic [7:0] o_cfg1,
   input logic [7:0] o_cfg2,
   input logic       o_soft_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_nrst);
   wire req = (i_low_supply_flag && o_cfg2[6])
      || (i_remote_overtemp_flag && o_cfg2[5])
      || (i_local_overtemp_flag && o_cfg2[4]);
   sequence s_pulse; o_soft_reset ##1 !o_soft_reset; endsequence
   sequence s_restored;
      o_cfg1 == 8'hD4 && !o_cfg2[6] && o_cfg2[4:0] == 5'h1D && !o_sda_oe;
   endsequence
   property p_pulse; $rose(o_soft_reset) |-> s_pulse; endproperty
   property p_restore; o_soft_reset |=> s_restored; endproperty
   property p_strap;
      o_soft_reset && i_remote_sensor_fail |-> ##[1:6] !o_cfg2[5];
   endproperty
   property p_bit7; o_cfg2[7] == 1'b0; endproperty
   property p_calc;
      !o_soft_reset |=> o_alert_oe == $past(o_cfg1[1] && req);
   endproperty
   property p_masked; !o_cfg1[1] |=> !o_alert_oe; endproperty
   property p_low;
      o_cfg1[1] && o_cfg2[6] && i_low_supply_flag && !o_soft_reset
         |=> o_alert_oe && !o_alert_out;
   endproperty
   property p_loc;
      o_cfg1[1] && o_cfg2[4] && i_local_overtemp_flag && !o_soft_reset
         |=> o_alert_oe;
   endproperty
   property p_rem;
      o_cfg1[1] && o_cfg2[5] && i_remote_overtemp_flag && !o_soft_reset
         |=> o_alert_oe;
   endproperty
   // Both open-drain lines may only ever pull low
   property p_drive; !o_alert_out && !o_sda_out; endproperty
   a_pulse: assert property (p_pulse)
      else $error("soft reset pulse not one cycle");
   a_restore: assert property (p_restore)
      else $error("soft reset did not restore defaults");
   a_strap: assert property (p_strap)
      else $error("remote enable kept after sensor failure");
   a_bit7: assert property (p_bit7)
      else $error("reset bit reads one");
   a_calc: assert property (p_calc)
      else $error("alert differs from enabled flags");
   a_masked: assert property (p_masked)
      else $error("alert while globally disabled");
   a_low: assert property (p_low)
      else $error("low supply alert missing");
   a_loc: assert property (p_loc)
      else $error("local over-temp alert missing");
   a_rem: assert property (p_rem)
      else $error("remote over-temp alert missing");
   a_drive: assert property (p_drive)
      else $error("open-drain line driven high");
endmodule

bind soft_reset_irq_cfg soft_reset_irq_cfg_chk u_chk (.i_sys_clk, .i_nrst,
   .i_low_supply_flag, .i_remote_overtemp_flag, .i_local_overtemp_flag,
   .i_remote_sensor_fail, .o_sda_out, .o_sda_oe, .o_alert_out, .o_alert_oe,
   .o_cfg1,
   .o_cfg2, .o_soft_reset);

// *** tb/smbus_host_model.sv ***
`include "fan_cfg_regs.vh"
module smbus_host_model (
   // Clock and line
   input  wire  i_clk,
   input  wire  i_sda,
   // Drive, release means pulled up
   output logic o_scl,
   output logic o_sda_rel
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_scl = 1'b1;
   initial o_sda_rel = 1'b1;
   task q;
      repeat (4) @(posedge i_clk);
   endtask
   task start;
      o_sda_rel <= 1'b1;
      q;
      o_scl <= 1'b1;
      q;
      o_sda_rel <= 1'b0;
      q;
      o_scl <= 1'b0;
      // Hold data past the clock fall before the first bit
      q;
   endtask
   task stop;
      o_sda_rel <= 1'b0;
      q;
      o_scl <= 1'b1;
      q;
      o_sda_rel <= 1'b1;
      q;
   endtask
   // Nine slots, last one is the acknowledge
   task bits(input logic [8:0] v, output logic [8:0] got);
      for (int i = 8; i >= 0; i--) begin
         o_sda_rel <= v[i];
         q;
         o_scl <= 1'b1;
         q;
         got[i] = i_sda;
         q;
         o_scl <= 1'b0;
         q;
      end
   endtask
   task wr(input logic [7:0] p, input logic [7:0] d, output logic nack);
      logic [8:0] g;
      start;
      bits({`DEV_SER_ADDR, 2'b01}, g);
      bits({p, 1'b1}, g);
      bits({d, 1'b1}, g);
      nack = g[0];
      stop;
   endtask
   task rd(input logic [7:0] p, output logic [7:0] d);
      logic [8:0] g;
      start;
      bits({`DEV_SER_ADDR, 2'b01}, g);
      bits({p, 1'b1}, g);
      start;
      bits({`DEV_SER_ADDR, 2'b11}, g);
      bits(9'h1FF, g);
      d = g[8:1];
      stop;
   endtask
endmodule

// *** tb/soft_reset_and_alarm_irq_enables_tb.sv ***
`include "fan_cfg_regs.vh"
module soft_reset_and_alarm_irq_enables_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       i_sys_clk = 1'b0;
   logic       i_nrst = 1'b0;
   logic [2:0] flg = 3'h0;
   logic       fail = 1'b0;
   wire        i_scl;
   wire        rel;
   logic       o_sda_out, o_sda_oe, o_alert_out, o_alert_oe, o_soft_reset;
   logic [7:0] o_cfg1, o_cfg2;
   int         bad_count = 0;
   int         num_checks = 0;
   // Open-drain lines with pull-ups
   wire        i_sda = rel & ~(o_sda_oe & ~o_sda_out);
   wire        alert_n = o_alert_oe ? o_alert_out : 1'b1;
   always #2.5 i_sys_clk = ~i_sys_clk;
   soft_reset_irq_cfg DUT (.i_sys_clk, .i_nrst, .i_scl, .i_sda, .o_sda_out,
      .o_sda_oe, .o_alert_out, .o_alert_oe, .i_low_supply_flag(flg[2]),
      .i_remote_overtemp_flag(flg[1]), .i_local_overtemp_flag(flg[0]),
      .i_remote_sensor_fail(fail), .o_cfg1, .o_cfg2, .o_soft_reset);
   smbus_host_model host (.i_clk(i_sys_clk), .i_sda(i_sda), .o_scl(i_scl),
      .o_sda_rel(rel));
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task settle;
      repeat (3) @(posedge i_sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d;
      logic       n;
      repeat (2) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      flg <= 3'h7;
      settle;
      chk("cfg2 port", 8'h3D, o_cfg2);
      chk("alert off", 8'h01, {7'h0, alert_n});
      host.rd(`CFG2_ADDR, d);
      chk("cfg2 read", 8'h3D, d);
      host.rd(8'h05, d);
      chk("unmapped read", 8'h00, d);
      $display("test defaults done");
      host.wr(`CFG1_ADDR, 8'hD6, n);
      chk("cfg1 ack", 8'h00, {7'h0, n});
      // Each enable alone, first with its flag, then with the others
      for (int i = 0; i < 3; i++) begin
         host.wr(`CFG2_ADDR, 8'(8'h40 >> i), n);
         chk("write ack", 8'h00, {7'h0, n});
         flg <= 3'(3'b100 >> i);
         settle;
         chk("alert pin", 8'h00, {7'h0, alert_n});
         flg <= ~3'(3'b100 >> i);
         settle;
         chk("alert masked", 8'h01, {7'h0, alert_n});
      end
      host.rd(`CFG2_ADDR, d);
      chk("cfg2 readback", 8'h10, d);
      $display("test enables done");
      fail <= 1'b1;
      host.wr(`CFG2_ADDR, 8'hC0, n);
      chk("reset nack", 8'h01, {7'h0, n});
      chk("cfg1 restored", 8'hD4, o_cfg1);
      host.rd(`CFG2_ADDR, d);
      chk("cfg2 failed sensor", 8'h1D, d);
      fail <= 1'b0;
      host.wr(`CFG2_ADDR, 8'h80, n);
      chk("reset nack again", 8'h01, {7'h0, n});
      settle;
      chk("cfg2 restored", 8'h3D, o_cfg2);
      $display("test soft reset done");
      // Pin reset in mid-run with a failed remote sensor
      fail <= 1'b1;
      i_nrst <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      chk("cfg2 power-on fail", 8'h1D, o_cfg2);
      chk("cfg1 power-on", 8'hD4, o_cfg1);
      host.rd(`CFG2_ADDR, d);
      chk("cfg2 read after reset", 8'h1D, d);
      fail <= 1'b0;
      $display("test power-on strap done");
      print_verdict;
   end
   initial begin
      #300000;
      bad_count++;
      print_verdict;
   end
endmodule
